/* File: design/ima_integration_irq_status_regs.sv */
// register bank: integration periods, overflow interrupt enables, general status
`timescale 1ns/10ps
module ima_integration_irq_status_regs #(
	parameter int BASE_SHIFT = ima_regs_pkg::BASE_SHIFT
) (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [11:0] addr,
	input  wire logic [15:0] wrData,
	input  wire logic        wrEn,
	input  wire logic        rdEn,
	input  wire logic [7:0]  groupOverflowStatus,
	input  wire logic [7:0]  rxFifoOverflowStatus,
	input  wire logic        utopiaOutClkFault,
	input  wire logic        utopiaInClkFault,
	input  wire logic        txFifoOverflow,
	input  wire logic        cellRamExhausted,
	output logic      [15:0] rdData,
	output logic      [7:0]  integrationTick,
	output logic             irqOut
);
	logic [3:0]  codeReg   [8];
	logic [3:0]  codeNext  [8];
	logic [22:0] cntReg    [8];
	logic [22:0] cntNext   [8];
	logic [7:0]  tickReg;
	logic [7:0]  tickNext;
	logic [7:0]  grpEnReg;
	logic [7:0]  grpEnNext;
	logic [7:0]  rxEnReg;
	logic [7:0]  rxEnNext;
	logic [3:0]  statReg;
	logic [3:0]  statNext;
	logic [15:0] rdReg;
	logic [15:0] rdNext;
	logic        irqReg;
	logic        irqNext;
	logic        intHit;
	logic [1:0]  pairIdx;
	logic [3:0]  statSet;

	// last count of one period; reserved code is clamped so a stray write stays bounded
	function automatic logic [22:0] periodLast(input logic [3:0] code);
		logic [3:0] c;
		c = (code == ima_regs_pkg::CODE_RESERVED) ? ima_regs_pkg::CODE_MAX : code;
		periodLast = 23'((23'h000001 << (BASE_SHIFT + int'(c))) - 23'h000001);
	endfunction : periodLast

	function automatic logic [15:0] pairWord(input logic [3:0] lo, input logic [3:0] hi);
		pairWord = {4'h0, hi, 4'h0, lo};
	endfunction : pairWord

	assign intHit  = (addr >= ima_regs_pkg::INT_BASE_OFS) && (addr <= ima_regs_pkg::INT_LAST_OFS);
	assign pairIdx = 2'(addr - ima_regs_pkg::INT_BASE_OFS);

	// integration settings and period counters
	always_comb begin
		for (int g = 0; g < ima_regs_pkg::GROUPS; g++) begin
			codeNext[g] = codeReg[g];
			tickNext[g] = 1'b0;
			if (cntReg[g] >= periodLast(codeReg[g])) begin
				cntNext[g]  = 23'h000000;
				tickNext[g] = 1'b1;
			end else begin
				cntNext[g] = cntReg[g] + 23'h000001;
			end
		end
		if (wrEn && intHit) begin
			// register n holds group n low and group n+4 high
			codeNext[pairIdx]      = wrData[ima_regs_pkg::LO_FIELD_POS +: 4];
			codeNext[pairIdx + 4]  = wrData[ima_regs_pkg::HI_FIELD_POS +: 4];
		end
	end

	always_ff @(posedge clock) begin
		for (int g = 0; g < ima_regs_pkg::GROUPS; g++) begin
			if (!nrst) begin
				codeReg[g] <= ima_regs_pkg::CODE_RESET;
				cntReg[g]  <= 23'h000000;
			end else begin
				codeReg[g] <= codeNext[g];
				cntReg[g]  <= cntNext[g];
			end
		end
		if (!nrst) begin
			tickReg <= 8'h00;
		end else begin
			tickReg <= tickNext;
		end
	end

	// enables and general status; a new event beats a clearing write
	assign statSet = {utopiaOutClkFault, utopiaInClkFault, txFifoOverflow, cellRamExhausted};

	always_comb begin
		grpEnNext = grpEnReg;
		rxEnNext  = rxEnReg;
		statNext  = statReg;
		if (wrEn && (addr == ima_regs_pkg::GRP_EN_OFS)) begin
			grpEnNext = wrData[7:0];
		end
		// receive enable sits in the line clock region in silicon, so it needs that clock up
		if (wrEn && (addr == ima_regs_pkg::RX_EN_OFS)) begin
			rxEnNext = wrData[7:0];
		end
		if (wrEn && (addr == ima_regs_pkg::GEN_STAT_OFS)) begin
			statNext = statReg & wrData[3:0];
		end
		statNext = statNext | statSet;
		irqNext  = |(groupOverflowStatus & grpEnReg) | |(rxFifoOverflowStatus & rxEnReg);
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			grpEnReg <= ima_regs_pkg::EN_RESET;
			rxEnReg  <= ima_regs_pkg::EN_RESET;
			statReg  <= ima_regs_pkg::STAT_RESET;
			irqReg   <= 1'b0;
		end else begin
			grpEnReg <= grpEnNext;
			rxEnReg  <= rxEnNext;
			statReg  <= statNext;
			irqReg   <= irqNext;
		end
	end

	// read port; unmapped addresses read zero
	always_comb begin
		rdNext = rdReg;
		if (rdEn) begin
			if (intHit) begin
				rdNext = pairWord(codeReg[pairIdx], codeReg[pairIdx + 4]);
			end else begin
				case (addr)
					ima_regs_pkg::GRP_EN_OFS:   rdNext = {8'h00, grpEnReg};
					ima_regs_pkg::RX_EN_OFS:    rdNext = {8'h00, rxEnReg};
					ima_regs_pkg::GEN_STAT_OFS: rdNext = {12'h000, statReg};
					default:                    rdNext = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdReg <= 16'h0000;
		end else begin
			rdReg <= rdNext;
		end
	end

	assign rdData          = rdReg;
	assign integrationTick = tickReg;
	assign irqOut          = irqReg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_writeInt0;
		wrEn && (addr == ima_regs_pkg::INT_BASE_OFS);
	endsequence

	a_reset_codes: assert property ($rose(nrst) |->
		pairWord(codeReg[0], codeReg[4]) == ima_regs_pkg::INT_RESET)
		else $error("integration register not at reset value");
	a_lo_field_write: assert property (s_writeInt0 |=> codeReg[0] == $past(wrData[3:0]))
		else $error("lower group field not written");
	a_hi_field_write: assert property (s_writeInt0 |=> codeReg[4] == $past(wrData[11:8]))
		else $error("upper group field not written");
	a_pair_read: assert property (rdEn && (addr == 12'h404) && !wrEn |=>
		rdData == {4'h0, $past(codeReg[5]), 4'h0, $past(codeReg[1])})
		else $error("pair register read wrong");
	a_tick_period: assert property ((codeReg[0] == 4'h0) && (cntReg[0] == 23'h0)
		&& !wrEn ##1 (codeReg[0] == 4'h0) [*2] |-> !integrationTick[0])
		else $error("period tick too early");
	a_grp_en_read: assert property (rdEn && (addr == ima_regs_pkg::GRP_EN_OFS) |=>
		(rdData[15:8] == 8'h00) && (rdData[7:0] == $past(grpEnReg)))
		else $error("group enable read wrong");
	a_rx_gate: assert property (((rxFifoOverflowStatus & rxEnReg) == 8'h00)
		&& ((groupOverflowStatus & grpEnReg) == 8'h00) |=> !irqOut)
		else $error("interrupt not suppressed");
	a_irq_cause: assert property (|(rxFifoOverflowStatus & rxEnReg) |=> irqOut)
		else $error("enabled overflow gave no interrupt");
	a_out_clk_hold: assert property (statReg[3] && !(wrEn && (addr ==
		ima_regs_pkg::GEN_STAT_OFS) && !wrData[3]) |=> statReg[3])
		else $error("output clock fault lost");
	a_in_clk_set: assert property (utopiaInClkFault |=> statReg[2] ##1 1'b1)
		else $error("input clock fault not latched");
	a_tx_ovf_set: assert property (txFifoOverflow |=> statReg[1])
		else $error("tx fifo overflow not shown");
	a_ram_clear: assert property (statReg[0] && !cellRamExhausted && wrEn
		&& (addr == ima_regs_pkg::GEN_STAT_OFS) && !wrData[0] |=> !statReg[0])
		else $error("cell memory flag not cleared");
	a_reset_codes_mid: assert property ($rose(nrst) |->
		(pairWord(codeReg[1], codeReg[5]) == ima_regs_pkg::INT_RESET)
		&& (pairWord(codeReg[2], codeReg[6]) == ima_regs_pkg::INT_RESET))
		else $error("middle integration registers not at reset value");
	a_reset_codes_hi: assert property ($rose(nrst) |->
		pairWord(codeReg[3], codeReg[7]) == ima_regs_pkg::INT_RESET)
		else $error("last integration register not at reset value");
	a_reset_enables: assert property ($rose(nrst) |->
		(grpEnReg == ima_regs_pkg::EN_RESET) && (rxEnReg == ima_regs_pkg::EN_RESET))
		else $error("interrupt enables not at reset value");
	a_reset_status: assert property ($rose(nrst) |->
		statReg == ima_regs_pkg::STAT_RESET)
		else $error("general status not at reset value");
	a_reset_outputs: assert property ($rose(nrst) |-> (rdData == 16'h0000)
		&& (integrationTick == 8'h00) && !irqOut)
		else $error("outputs not idle after reset");

	sequence s_writeInt1;
		wrEn && (addr == ima_regs_pkg::INT_BASE_OFS + 12'h001);
	endsequence

	sequence s_writeInt2;
		wrEn && (addr == ima_regs_pkg::INT_BASE_OFS + 12'h002);
	endsequence

	sequence s_writeInt3;
		wrEn && (addr == ima_regs_pkg::INT_LAST_OFS);
	endsequence

	sequence s_writeGrpEn;
		wrEn && (addr == ima_regs_pkg::GRP_EN_OFS);
	endsequence

	sequence s_writeRxEn;
		wrEn && (addr == ima_regs_pkg::RX_EN_OFS);
	endsequence

	// a clear of bit 3 in the middle cycle would hide the event from the read
	sequence s_outFaultThenRead;
		utopiaOutClkFault
		##1 !(wrEn && (addr == ima_regs_pkg::GEN_STAT_OFS) && !wrData[3])
		##1 rdEn && (addr == ima_regs_pkg::GEN_STAT_OFS);
	endsequence

	a_int1_lo_write: assert property (s_writeInt1 |=> codeReg[1] == $past(wrData[3:0]))
		else $error("group 1 code not written");
	a_int1_hi_write: assert property (s_writeInt1 |=> codeReg[5] == $past(wrData[11:8]))
		else $error("group 5 code not written");
	a_int2_lo_write: assert property (s_writeInt2 |=> codeReg[2] == $past(wrData[3:0]))
		else $error("group 2 code not written");
	a_int2_hi_write: assert property (s_writeInt2 |=> codeReg[6] == $past(wrData[11:8]))
		else $error("group 6 code not written");
	a_int3_lo_write: assert property (s_writeInt3 |=> codeReg[3] == $past(wrData[3:0]))
		else $error("group 3 code not written");
	a_int3_hi_write: assert property (s_writeInt3 |=> codeReg[7] == $past(wrData[11:8]))
		else $error("group 7 code not written");
	a_int0_read: assert property (rdEn && (addr == ima_regs_pkg::INT_BASE_OFS) |=>
		rdData == {4'h0, $past(codeReg[4]), 4'h0, $past(codeReg[0])})
		else $error("first integration register read wrong");
	a_int3_read: assert property (rdEn && (addr == ima_regs_pkg::INT_LAST_OFS) |=>
		rdData == {4'h0, $past(codeReg[7]), 4'h0, $past(codeReg[3])})
		else $error("last integration register read wrong");
	a_grp_en_write: assert property (s_writeGrpEn |=> grpEnReg == $past(wrData[7:0]))
		else $error("group enable not written");
	a_rx_en_write: assert property (s_writeRxEn |=> rxEnReg == $past(wrData[7:0]))
		else $error("receive enable not written");
	a_rx_en_read: assert property (rdEn && (addr == ima_regs_pkg::RX_EN_OFS) |=>
		(rdData[15:8] == 8'h00) && (rdData[7:0] == $past(rxEnReg)))
		else $error("receive enable read wrong");
	a_stat_read: assert property (rdEn && (addr == ima_regs_pkg::GEN_STAT_OFS) |=>
		rdData == {12'h000, $past(statReg)})
		else $error("general status read wrong");
	a_out_clk_read: assert property (s_outFaultThenRead |=> rdData[3])
		else $error("output clock fault not seen by a read");
	a_out_clk_set: assert property (utopiaOutClkFault |=> statReg[3])
		else $error("output clock fault not latched");
	a_in_clk_hold: assert property (statReg[2] && !(wrEn && (addr ==
		ima_regs_pkg::GEN_STAT_OFS) && !wrData[2]) |=> statReg[2])
		else $error("input clock fault lost");
	a_tx_ovf_hold: assert property (statReg[1] && !(wrEn && (addr ==
		ima_regs_pkg::GEN_STAT_OFS) && !wrData[1]) |=> statReg[1])
		else $error("tx fifo overflow flag lost");
	a_ram_set: assert property (cellRamExhausted |=> statReg[0])
		else $error("cell memory flag not latched");
	a_ram_hold: assert property (statReg[0] && !(wrEn && (addr ==
		ima_regs_pkg::GEN_STAT_OFS) && !wrData[0]) |=> statReg[0])
		else $error("cell memory flag lost");
	a_out_clk_clear: assert property (statReg[3] && !utopiaOutClkFault && wrEn
		&& (addr == ima_regs_pkg::GEN_STAT_OFS) && !wrData[3] |=> !statReg[3])
		else $error("output clock flag not cleared");
	a_in_clk_clear: assert property (statReg[2] && !utopiaInClkFault && wrEn
		&& (addr == ima_regs_pkg::GEN_STAT_OFS) && !wrData[2] |=> !statReg[2])
		else $error("input clock flag not cleared");
	a_tx_ovf_clear: assert property (statReg[1] && !txFifoOverflow && wrEn
		&& (addr == ima_regs_pkg::GEN_STAT_OFS) && !wrData[1] |=> !statReg[1])
		else $error("tx fifo overflow flag not cleared");
	a_ram_set_wins: assert property (cellRamExhausted && wrEn
		&& (addr == ima_regs_pkg::GEN_STAT_OFS) && !wrData[0] |=> statReg[0])
		else $error("clearing write hid a new cell memory event");
	a_grp_irq: assert property (|(groupOverflowStatus & grpEnReg) |=> irqOut)
		else $error("enabled group overflow gave no interrupt");
	a_tick_on_wrap: assert property ((cntReg[0] == 23'h000000)
		&& ($past(cntReg[0]) != 23'h000000) |-> integrationTick[0])
		else $error("group 0 tick missing at wrap");
	a_tick_hi_wrap: assert property ((cntReg[4] == 23'h000000)
		&& ($past(cntReg[4]) != 23'h000000) |-> integrationTick[4])
		else $error("group 4 tick missing at wrap");
	a_tick0_only: assert property (integrationTick[0] |-> cntReg[0] == 23'h000000)
		else $error("group 0 tick without wrap");
	a_tick4_only: assert property (integrationTick[4] |-> cntReg[4] == 23'h000000)
		else $error("group 4 tick without wrap");
	a_rd_hold: assert property (!rdEn |=> $stable(rdData))
		else $error("read data changed without a read");
	a_cnt_bound: assert property (cntReg[0] <= periodLast(ima_regs_pkg::CODE_MAX))
		else $error("group 0 counter beyond longest period");
endmodule : ima_integration_irq_status_regs

/* File: common/ima_regs_pkg.sv */
// constants for the integration and interrupt-status register bank
// Contract
// - bits 3:0 of each integration register pick lower group period, power of two
// - bits 11:8 pick the upper group period with the same encoding
// - four integration registers cover eight groups, register n also carries group n+4
// - code 0000 gives 2^8 cycles, each step doubles, 1110 gives 2^22
// - integration registers reset with both fields 1100, reserved bits zero
// - group overflow enable bits 7:0 gate interrupts; bits 15:8 read zero
// - receive group FIFO overflow enable bits 7:0 allow or suppress interrupts
// - status bit 3 latches on missing or slow UTOPIA output clock, write 0 clears
// - status bit 2 latches on missing or slow UTOPIA input clock, write 0 clears
// - status bit 1 shows that some transmit UTOPIA FIFO overflowed
// - status bit 0 latches when transmit cell memory is full, write 0 clears
package ima_regs_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 16;
	localparam int          GROUPS        = 8;
	localparam int          PAIRS         = 4;
	localparam int          CNT_W         = 23;
	localparam int          CODE_W        = 4;
	localparam logic [11:0] INT_BASE_OFS  = 12'h403;
	localparam logic [11:0] INT_LAST_OFS  = 12'h406;
	localparam logic [11:0] GRP_EN_OFS    = 12'h40B;
	localparam logic [11:0] RX_EN_OFS     = 12'h40C;
	localparam logic [11:0] GEN_STAT_OFS  = 12'h40E;
	localparam int          LO_FIELD_POS  = 0;
	localparam int          HI_FIELD_POS  = 8;
	localparam logic [3:0]  CODE_RESET    = 4'hC;
	localparam logic [3:0]  CODE_RESERVED = 4'hF;
	localparam logic [3:0]  CODE_MAX      = 4'hE;
	localparam logic [15:0] INT_RESET     = 16'h0C0C;
	localparam logic [7:0]  EN_RESET      = 8'h00;
	localparam logic [3:0]  STAT_RESET    = 4'h0;
	localparam int          ST_RAM_FULL   = 0;
	localparam int          ST_TX_OVF     = 1;
	localparam int          ST_IN_CLK     = 2;
	localparam int          ST_OUT_CLK    = 3;
	localparam int          BASE_SHIFT    = 8;
endpackage : ima_regs_pkg

/* File: verif/tb_top.sv */
// self-checking bench for the integration period and status register bank
`timescale 1ns/10ps
module tb_top;
	logic        clock = 0;
	logic        nrst = 0;
	logic [11:0] addr = 0;
	logic [15:0] wrData = 0;
	logic        wrEn = 0;
	logic        rdEn = 0;
	logic [7:0]  grpSt = 0;
	logic [7:0]  rxSt = 0;
	logic [3:0]  ev = 0;
	logic [15:0] rdData;
	logic [7:0]  tick;
	logic        irqOut;
	logic [15:0] intM [4];
	logic [7:0]  grpEn = 0;
	logic [7:0]  rxEn = 0;
	logic [3:0]  stM = 0;
	logic [31:0] seed = 91;
	logic [11:0] at [8] = '{12'h403, 12'h404, 12'h405, 12'h406, 12'h40B, 12'h40C, 12'h40E, 12'h40D};
	int          num_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	always #10 clock = ~clock; // free running, never gated
	// short periods: 2^(2+code) cycles keep the tick test brief
	ima_integration_irq_status_regs #(.BASE_SHIFT(2)) i_dut (.clock(clock), .nrst(nrst),
		.addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .groupOverflowStatus(grpSt),
		.rxFifoOverflowStatus(rxSt), .utopiaOutClkFault(ev[3]), .utopiaInClkFault(ev[2]),
		.txFifoOverflow(ev[1]), .cellRamExhausted(ev[0]), .rdData(rdData),
		.integrationTick(tick), .irqOut(irqOut));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] ex(logic [11:0] a);
		if (a >= 12'h403 && a <= 12'h406) return intM[a - 12'h403];
		if (a == 12'h40B) return {8'h00, grpEn};
		if (a == 12'h40C) return {8'h00, rxEn};
		if (a == 12'h40E) return {12'h000, stM};
		return 16'h0000;
	endfunction : ex
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(logic [11:0] a, logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clock);
		wrEn <= 1'b0;
		if (a >= 12'h403 && a <= 12'h406) intM[a - 12'h403] = d & 16'h0F0F;
		if (a == 12'h40B) grpEn = d[7:0];
		if (a == 12'h40C) rxEn = d[7:0];
		if (a == 12'h40E) stM &= d[3:0];
	endtask : wr
	task automatic rd(logic [11:0] a);
		@(posedge clock);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clock);
		rdEn <= 1'b0;
		#1 chk(rdData, ex(a));
	endtask : rd
	task automatic evt(logic [3:0] v);
		@(posedge clock);
		ev <= v;
		@(posedge clock);
		ev <= 4'h0;
		stM |= v;
	endtask : evt
	task automatic mt(int g, int p);
		int c;
		c = 0;
		do begin @(posedge clock); #1; end while (tick[g] !== 1'b1);
		do begin @(posedge clock); #1; c++; end while (tick[g] !== 1'b1);
		chk(c, p);
	endtask : mt
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		logic [15:0] d;
		for (int i = 0; i < 4; i++) intM[i] = 16'h0C0C;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) rd(at[i]);
		$display("test reset values done");
		for (int i = 0; i < 60; i++) begin
			d = 16'(rnd());
			// code 1111 is reserved, software never writes it
			if (d[3:0] == 4'hF) d[3] = 1'b0;
			if (d[11:8] == 4'hF) d[11] = 1'b0;
			if (rnd() & 1) wr(at[rnd() % 8], d);
			else rd(at[rnd() % 8]);
		end
		$display("test random access done");
		evt(4'hF);
		rd(12'h40E);
		wr(12'h40E, 16'hFFFA);
		rd(12'h40E);
		evt(4'h2);
		wr(12'h40E, 16'h0000);
		rd(12'h40E);
		@(posedge clock);
		addr <= 12'h40E;
		wrData <= 16'h0000;
		wrEn <= 1'b1;
		ev <= 4'h1;
		@(posedge clock);
		wrEn <= 1'b0;
		ev <= 4'h0;
		stM = 4'h1;
		rd(12'h40E);
		$display("test status done");
		for (int i = 0; i < 24; i++) begin
			wr(12'h40B, 16'(rnd()));
			wr(12'h40C, 16'(rnd()));
			@(posedge clock);
			grpSt <= 8'(rnd() & rnd() & rnd());
			rxSt <= 8'(rnd() & rnd() & rnd());
			repeat (2) @(posedge clock);
			#1 chk(irqOut, |(grpSt & grpEn) || |(rxSt & rxEn));
		end
		$display("test interrupt done");
		for (int n = 0; n < 4; n++) wr(12'h403 + 12'(n), {4'h0, 4'(n + 4), 4'h0, 4'(n)});
		for (int g = 0; g < 8; g++) mt(g, 1 << (2 + g));
		$display("test period done");
		wr(12'h403, 16'h0B0C);
		wr(12'h404, 16'h090B);
		rd(12'h403);
		rd(12'h404);
		mt(5, 1 << 11);
		$display("test recommended codes done");
		@(posedge clock);
		nrst <= 1'b0;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 4; i++) intM[i] = 16'h0C0C;
		grpEn = 8'h00;
		rxEn = 8'h00;
		stM = 4'h0;
		for (int i = 0; i < 8; i++) rd(at[i]);
		chk(irqOut, 1'b0);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule : tb_top
